// ---- rtl/asc_pkg.sv ----
// asc_pkg: constants for the sampling / clamp control block.
// assumes a 32-bit AHB-Lite slave with word-aligned registers.
`default_nettype none
package asc_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ASC_OFF_CTRL   = 8'h00; // mode, select, clamp, timing
  localparam logic [7:0] ASC_OFF_REF    = 8'h04; // reference dac control
  localparam logic [7:0] ASC_OFF_RED    = 8'h08; // red offset / gain
  localparam logic [7:0] ASC_OFF_GREEN  = 8'h0C; // green offset / gain
  localparam logic [7:0] ASC_OFF_BLUE   = 8'h10; // blue offset / gain
  localparam logic [7:0] ASC_OFF_SWRST  = 8'h14; // any write restores defaults
  localparam logic [7:0] ASC_OFF_STATUS = 8'h18; // read-only state

  // ==========================================================
  // control register fields
  localparam int ASC_CTRL_SEL_LSB  = 0; // colour_set_select [1:0]
  localparam int ASC_CTRL_MONO     = 2; // 1 = monochrome
  localparam int ASC_CTRL_CLAMP_EN = 3; // clamp_enable
  localparam int ASC_CTRL_RST_LSB  = 4; // reset_sample_timing [5:4]
  localparam int ASC_CTRL_DSAMP    = 6; // double_sample_select
  // reference register fields
  localparam int ASC_REF_CODE_LSB  = 0; // reference_level_code [3:0]
  localparam int ASC_REF_RANGE     = 4; // reference_dac_range
  localparam int ASC_REF_EXT       = 5; // external_reference_select
  // colour set register fields
  localparam int ASC_SET_OFF_LSB   = 0; // offset value [7:0]
  localparam int ASC_SET_GAIN_LSB  = 8; // gain value [15:8]

  // ==========================================================
  // reset values
  localparam logic [31:0] ASC_CTRL_RST = 32'h0000_0040; // double sampling on
  localparam logic [31:0] ASC_REF_RST  = 32'h0000_0000;
  localparam logic [31:0] ASC_SET_RST  = 32'h0000_0080; // mid offset, min gain

  // ==========================================================
  // colour select codes
  localparam logic [1:0] ASC_SEL_RED   = 2'h0;
  localparam logic [1:0] ASC_SEL_GREEN = 2'h1;
  localparam logic [1:0] ASC_SEL_BLUE  = 2'h2;

  // ==========================================================
  // timing counts, in master clock cycles
  localparam logic [2:0] ASC_RS_BASE     = 3'h1; // strobe to reset sample base
  localparam int         ASC_CLAMP_WIDTH = 2;    // clamp pulse length
  localparam int         ASC_NIBBLES     = 4;    // nibbles per 16-bit word

endpackage
`default_nettype wire

// ---- rtl/asc_nib_if.sv ----
// asc_nib_if: word hand-off from control core to nibble serialiser.
// assumes both ends share ref_clk_i.
`timescale 1ns/100ps
`default_nettype none
interface asc_nib_if;
  logic [15:0] word;     // converted sample
  logic        load;     // one-cycle load strobe
  logic        busy;     // serialiser still shifting
  logic [3:0]  nibble;   // output nibble
  logic        nib_vld;  // nibble valid
  modport core (output word, load, input busy, nibble, nib_vld);
  modport ser  (input word, load, output busy, nibble, nib_vld);
endinterface
`default_nettype wire

// ---- rtl/asc_nibble_ser.sv ----
// asc_nibble_ser: shifts a 16-bit word out as four nibbles, msb first.
// assumes load is ignored while busy; the core guards against that.
`timescale 1ns/100ps
`default_nettype none
module asc_nibble_ser (
  input  wire logic ref_clk_i, // master clock
  input  wire logic rst_n_i,   // async reset, active low
  asc_nib_if.ser    nif        // link to the core
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] sh;   // shift register
    logic [1:0]  cnt;  // nibbles left minus one
    logic        busy; // shifting
    logic [3:0]  nib;  // current nibble
    logic        nv;   // nibble valid
  } asc_ser_state_t;

  asc_ser_state_t st_ff;  // registered state
  asc_ser_state_t nxt_st; // next state

  // next-state logic
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.nv = 1'b0;
    if (st_ff.busy) begin
      // emit top nibble, then shift
      nxt_st.nib = st_ff.sh[15:12];
      nxt_st.nv  = 1'b1;
      nxt_st.sh  = {st_ff.sh[11:0], 4'h0};
      nxt_st.cnt = st_ff.cnt - 2'h1;
      if (st_ff.cnt == 2'h0) begin
        nxt_st.busy = 1'b0;
      end
    end else if (nif.load) begin
      nxt_st.sh   = nif.word;
      nxt_st.cnt  = 2'(asc_pkg::ASC_NIBBLES - 1);
      nxt_st.busy = 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign nif.busy    = st_ff.busy;
  assign nif.nibble  = st_ff.nib;
  assign nif.nib_vld = st_ff.nv;

endmodule
`default_nettype wire

// ---- rtl/asc_ctrl.sv ----
// asc_ctrl: control core of a single-channel imaging front end.
// assumes supply monitors give synchronous levels and that the
// sample strobe is synchronous to ref_clk_i, the master clock.
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl #(
  parameter int CLAMP_WIDTH = asc_pkg::ASC_CLAMP_WIDTH // clamp cycles
) (
  input  wire logic        ref_clk_i,          // master clock, 50 MHz
  input  wire logic        rst_n_i,            // async reset, active low
  input  wire logic        avdd_ok_i,          // analogue supply above threshold
  input  wire logic        dvdd_ok_i,          // core supply above threshold
  input  wire logic        hsel_i,             // ahb select
  input  wire logic [31:0] haddr_i,            // ahb address
  input  wire logic [1:0]  htrans_i,           // ahb transfer type
  input  wire logic        hwrite_i,           // ahb write
  input  wire logic [2:0]  hsize_i,            // ahb size, words only
  input  wire logic [31:0] hwdata_i,           // ahb write data
  input  wire logic        hready_i,           // ahb bus ready
  output logic      [31:0] hrdata_o,           // ahb read data
  output logic             hreadyout_o,        // always ready
  output logic             hresp_o,            // always okay
  input  wire logic        sample_strobe_i,    // pixel sample strobe
  input  wire logic [15:0] adc_word_i,         // converted sample
  input  wire logic        adc_word_valid_i,   // sample word strobe
  output logic             power_good_n_o,     // low holds registers and clamp state in reset
  output logic             clamp_pulse_o,      // internal clamp pulse
  output logic             clamp_switch_o,     // clamp switch closed
  output logic             video_sample_o,     // video level sample strobe
  output logic             ref_sample_o,       // reference sample strobe
  output logic             ref_from_reset_o,   // reference is reset level
  output logic      [3:0]  ref_level_code_o,   // reference dac code
  output logic             ref_dac_range_o,    // wide dac range
  output logic             ref_dac_enable_o,   // internal dac drives pin
  output logic      [7:0]  offset_code_o,      // applied offset value
  output logic      [7:0]  gain_code_o,        // applied gain value
  output logic      [3:0]  nibble_o,           // output nibble bus
  output logic             nibble_valid_o      // nibble valid
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] ctrl;      // control register
    logic [31:0] refc;      // reference register
    logic [15:0] red;       // red set
    logic [15:0] green;     // green set
    logic [15:0] blue;      // blue set
    logic        wr_pend;   // write data phase pending
    logic [7:0]  wr_addr;   // latched write offset
    logic [31:0] rdata;     // read data for data phase
    logic        strb_prev; // strobe last cycle
    logic        clamp_cap; // captured clamp enable
    logic        pend;      // reset sample pending
    logic [2:0]  cnt;       // cycles until reset sample
    logic        clamp_on;  // clamp pulse active
    logic [1:0]  wcnt;      // clamp cycles left minus one
    logic        rs_pulse;  // reset sample instant
    logic        vs_pulse;  // video sample instant
    logic [7:0]  offset;    // applied offset
    logic [7:0]  gain;      // applied gain
    logic [15:0] word;      // word to serialiser
    logic        load;      // load strobe to serialiser
  } asc_state_t;

  asc_state_t st_ff;   // registered state
  asc_state_t nxt_st;  // next state
  logic       pg;      // supplies both good
  logic       strb_rise; // first cycle of a strobe pulse
  logic       fire;    // reset sample instant reached

  asc_nib_if nif ();   // link to serialiser

  // ==========================================================
  // power good
  // either supply low
  assign pg             = avdd_ok_i && dvdd_ok_i;
  assign power_good_n_o = pg;

  // ==========================================================
  // read mux, status is built from live state
  function automatic logic [31:0] rd_word(input logic [7:0] a, input asc_state_t s,
                                          input logic p, input logic b);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      asc_pkg::ASC_OFF_CTRL:   r = s.ctrl;
      asc_pkg::ASC_OFF_REF:    r = s.refc;
      asc_pkg::ASC_OFF_RED:    r = {16'h0000, s.red};
      asc_pkg::ASC_OFF_GREEN:  r = {16'h0000, s.green};
      asc_pkg::ASC_OFF_BLUE:   r = {16'h0000, s.blue};
      asc_pkg::ASC_OFF_STATUS: r = {28'h000_0000, b, s.clamp_on, s.clamp_cap, p};
      default:                 r = 32'h0000_0000; // unmapped and reset reg read zero
    endcase
    return r;
  endfunction

  assign strb_rise = sample_strobe_i && !st_ff.strb_prev;
  assign fire      = st_ff.pend && (st_ff.cnt == 3'h0) && !strb_rise;

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // bus address phase, zero wait states
    nxt_st.wr_pend = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      nxt_st.wr_pend = hwrite_i;
      nxt_st.wr_addr = haddr_i[7:0];
      nxt_st.rdata   = hwrite_i ? 32'h0000_0000 : rd_word(haddr_i[7:0], st_ff, pg, nif.busy);
    end
    // bus data phase
    if (st_ff.wr_pend) begin
      unique case (st_ff.wr_addr)
        asc_pkg::ASC_OFF_CTRL:  nxt_st.ctrl  = {25'h000_0000, hwdata_i[6:0]};
        asc_pkg::ASC_OFF_REF:   nxt_st.refc  = {26'h000_0000, hwdata_i[5:0]};
        asc_pkg::ASC_OFF_RED:   nxt_st.red   = hwdata_i[15:0];
        asc_pkg::ASC_OFF_GREEN: nxt_st.green = hwdata_i[15:0];
        asc_pkg::ASC_OFF_BLUE:  nxt_st.blue  = hwdata_i[15:0];
        asc_pkg::ASC_OFF_SWRST: begin
          // soft reset restores every default
          nxt_st.ctrl  = asc_pkg::ASC_CTRL_RST;
          nxt_st.refc  = asc_pkg::ASC_REF_RST;
          nxt_st.red   = asc_pkg::ASC_SET_RST[15:0];
          nxt_st.green = asc_pkg::ASC_SET_RST[15:0];
          nxt_st.blue  = asc_pkg::ASC_SET_RST[15:0];
        end
        default: ; // unmapped writes vanish, still okay
      endcase
    end

    // ----------------------------------------------------------
    // clamp and sample timing
    nxt_st.strb_prev = sample_strobe_i;
    nxt_st.vs_pulse  = strb_rise;
    nxt_st.rs_pulse  = 1'b0;
    if (st_ff.clamp_on) begin
      if (st_ff.wcnt == 2'h0) begin
        nxt_st.clamp_on = 1'b0;
      end else begin
        nxt_st.wcnt = st_ff.wcnt - 2'h1;
      end
    end
    if (strb_rise) begin
      nxt_st.clamp_cap = st_ff.ctrl[asc_pkg::ASC_CTRL_CLAMP_EN];
      nxt_st.pend      = 1'b1;
      nxt_st.cnt       = asc_pkg::ASC_RS_BASE + {1'b0, st_ff.ctrl[asc_pkg::ASC_CTRL_RST_LSB +: 2]};
    end else if (st_ff.pend) begin
      if (fire) begin
        nxt_st.pend = 1'b0;
        // reset sampled whether clamped or not
        nxt_st.rs_pulse = 1'b1;
        // clamp only when captured enable set
        if (st_ff.clamp_cap) begin
          nxt_st.clamp_on = 1'b1;
          nxt_st.wcnt     = 2'(CLAMP_WIDTH - 1);
        end
      end else begin
        nxt_st.cnt = st_ff.cnt - 3'h1;
      end
    end

    // ----------------------------------------------------------
    // applied coefficient set
    if (st_ff.ctrl[asc_pkg::ASC_CTRL_MONO]) begin
      nxt_st.offset = st_ff.red[asc_pkg::ASC_SET_OFF_LSB +: 8];
      nxt_st.gain   = st_ff.red[asc_pkg::ASC_SET_GAIN_LSB +: 8];
    end else begin
      unique case (st_ff.ctrl[asc_pkg::ASC_CTRL_SEL_LSB +: 2])
        asc_pkg::ASC_SEL_RED: begin
          nxt_st.offset = st_ff.red[asc_pkg::ASC_SET_OFF_LSB +: 8];
          nxt_st.gain   = st_ff.red[asc_pkg::ASC_SET_GAIN_LSB +: 8];
        end
        asc_pkg::ASC_SEL_GREEN: begin
          nxt_st.offset = st_ff.green[asc_pkg::ASC_SET_OFF_LSB +: 8];
          nxt_st.gain   = st_ff.green[asc_pkg::ASC_SET_GAIN_LSB +: 8];
        end
        asc_pkg::ASC_SEL_BLUE: begin
          nxt_st.offset = st_ff.blue[asc_pkg::ASC_SET_OFF_LSB +: 8];
          nxt_st.gain   = st_ff.blue[asc_pkg::ASC_SET_GAIN_LSB +: 8];
        end
        default: ; // reserved code keeps the set in use
      endcase
    end

    // ----------------------------------------------------------
    // sample words to serialiser, dropped while it is busy
    nxt_st.load = 1'b0;
    if (adc_word_valid_i && !nif.busy && !st_ff.load) begin
      nxt_st.word = adc_word_i;
      nxt_st.load = 1'b1;
    end

    // ----------------------------------------------------------
    // power reset overrides the register, clamp and reset sample state above
    if (!pg) begin
      nxt_st.ctrl  = asc_pkg::ASC_CTRL_RST;
      nxt_st.refc  = asc_pkg::ASC_REF_RST;
      nxt_st.red   = asc_pkg::ASC_SET_RST[15:0];
      nxt_st.green = asc_pkg::ASC_SET_RST[15:0];
      nxt_st.blue  = asc_pkg::ASC_SET_RST[15:0];
      nxt_st.clamp_cap = 1'b0;
      nxt_st.pend     = 1'b0;
      nxt_st.clamp_on = 1'b0;
      nxt_st.rs_pulse = 1'b0;
    end
  end

  // ==========================================================
  // state register, reset to the register defaults
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff       <= '0;
      st_ff.ctrl  <= asc_pkg::ASC_CTRL_RST;
      st_ff.refc  <= asc_pkg::ASC_REF_RST;
      st_ff.red   <= asc_pkg::ASC_SET_RST[15:0];
      st_ff.green <= asc_pkg::ASC_SET_RST[15:0];
      st_ff.blue  <= asc_pkg::ASC_SET_RST[15:0];
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // serialiser
  assign nif.word = st_ff.word;
  assign nif.load = st_ff.load;

  asc_nibble_ser u_ser (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .nif       (nif)
  );

  // ==========================================================
  // outputs
  assign hrdata_o       = st_ff.rdata;
  assign hreadyout_o    = 1'b1;
  assign hresp_o        = 1'b0;
  assign clamp_pulse_o  = st_ff.clamp_on;
  assign clamp_switch_o = st_ff.clamp_on;
  assign video_sample_o = st_ff.vs_pulse;
  assign ref_sample_o     = st_ff.ctrl[asc_pkg::ASC_CTRL_DSAMP] ? st_ff.rs_pulse : st_ff.vs_pulse;
  assign ref_from_reset_o = st_ff.ctrl[asc_pkg::ASC_CTRL_DSAMP];
  assign ref_level_code_o = st_ff.refc[asc_pkg::ASC_REF_CODE_LSB +: 4];
  assign ref_dac_range_o  = st_ff.refc[asc_pkg::ASC_REF_RANGE];
  assign ref_dac_enable_o = !st_ff.refc[asc_pkg::ASC_REF_EXT];
  assign offset_code_o    = st_ff.offset;
  assign gain_code_o      = st_ff.gain;
  assign nibble_o         = nif.nibble;
  assign nibble_valid_o   = nif.nib_vld;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_pg_low;
    (!avdd_ok_i || !dvdd_ok_i) |-> !power_good_n_o ##1 (st_ff.clamp_cap == 1'b0);
  endproperty
  a_pg_low: assert property (p_pg_low) else $error("supply low did not hold reset");

  property p_por_discard;
    (!pg && st_ff.wr_pend) |=> (st_ff.ctrl == asc_pkg::ASC_CTRL_RST) && (st_ff.red == 16'h0080);
  endproperty
  a_por_discard: assert property (p_por_discard) else $error("write taken during power reset");

  property p_por_release;
    $rose(pg) |-> (st_ff.ctrl == asc_pkg::ASC_CTRL_RST) && (st_ff.refc == asc_pkg::ASC_REF_RST);
  endproperty
  a_por_release: assert property (p_por_release) else $error("registers not default at release");

  property p_mono;
    (pg && st_ff.ctrl[2]) |=> (offset_code_o == $past(st_ff.red[7:0]));
  endproperty
  a_mono: assert property (p_mono) else $error("monochrome offset not red pair");

  property p_green;
    (pg && !st_ff.ctrl[2] && st_ff.ctrl[1:0] == 2'h1) |=> (gain_code_o == $past(st_ff.green[15:8]));
  endproperty
  a_green: assert property (p_green) else $error("green set not applied");

  property p_capture;
    (pg && strb_rise) |=> (st_ff.clamp_cap == $past(st_ff.ctrl[3]));
  endproperty
  a_capture: assert property (p_capture) else $error("clamp enable not captured");

  property p_hold;
    (pg && !strb_rise) |=> $stable(st_ff.clamp_cap);
  endproperty
  a_hold: assert property (p_hold) else $error("captured enable changed between strobes");

  property p_place;
    (pg && strb_rise && st_ff.ctrl[3] && st_ff.ctrl[5:4] == 2'h0) ##1 (pg && !strb_rise)[*2]
      |=> $rose(clamp_pulse_o);
  endproperty
  a_place: assert property (p_place) else $error("clamp pulse misplaced");

  property p_width;
    (pg && $rose(clamp_pulse_o)) |-> clamp_pulse_o ##1 (clamp_pulse_o || !pg) ##1 !clamp_pulse_o;
  endproperty
  a_width: assert property (p_width) else $error("clamp pulse width wrong");

  property p_no_clamp;
    !pg |=> !clamp_pulse_o;
  endproperty
  a_no_clamp: assert property (p_no_clamp) else $error("clamp during power reset");

  property p_ext;
    st_ff.refc[5] |-> !ref_dac_enable_o && (ref_level_code_o == st_ff.refc[3:0]);
  endproperty
  a_ext: assert property (p_ext) else $error("internal dac left on");

  property p_single;
    (!st_ff.ctrl[6] && video_sample_o) |-> ref_sample_o && !ref_from_reset_o;
  endproperty
  a_single: assert property (p_single) else $error("reference not sampled with video");

  c_clamp:  cover property ($rose(clamp_pulse_o));
  c_swrst:  cover property (st_ff.wr_pend && st_ff.wr_addr == asc_pkg::ASC_OFF_SWRST);
  c_nibble: cover property (nibble_valid_o [*4]);
  c_blue:   cover property (!st_ff.ctrl[2] && st_ff.ctrl[1:0] == 2'h2);

endmodule
`default_nettype wire

// ---- dv/asc_strobe_model.sv ----
// asc_strobe_model: scanner timing controller side, pixel strobe and words.
// assumes the bench raises fire_i for one cycle per pixel.
`timescale 1ns/100ps
`default_nettype none
module asc_strobe_model (
  input  wire logic        ref_clk_i,        // master clock
  input  wire logic        fire_i,           // request one pixel
  input  wire logic [15:0] word_i,           // word for that pixel
  output logic             sample_strobe_o,  // one-cycle strobe
  output logic      [15:0] adc_word_o,       // sample word
  output logic             adc_word_valid_o  // word strobe
);
  // ==========================================
  // pixel driver, one process so each output has a single driver
  // idle word is the inverse of the last word so stale data never looks valid
  always @(posedge ref_clk_i) begin
    sample_strobe_o  <= fire_i;
    adc_word_valid_o <= fire_i;
    adc_word_o       <= fire_i ? word_i : ~word_i;
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// tb_top: register, power and clamp checks of the control core.
// assumes one 50 MHz clock and the bench as the only bus master.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ==========================================
  // signals
  localparam int CW = 2;             // clamp width under test
  logic        clk = 1'b0, rst_n = 1'b0, av = 1'b1, dv = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp, fire = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [15:0] fword = 16'h0000, aword;
  logic        stb, avld, pgn, clamp, csw, vsam, rsmp, rfr, rrng, rdac, nvld;
  logic [3:0]  rcode, nib;
  logic [7:0]  offs, gain;
  int          err_total = 0, cmp_count = 0, cyc = 0;
  always #10 clk = ~clk;
  // ==========================================
  // design and far side
  asc_ctrl #(.CLAMP_WIDTH(CW)) dut (.ref_clk_i(clk), .rst_n_i(rst_n), .avdd_ok_i(av), .dvdd_ok_i(dv),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .sample_strobe_i(stb), .adc_word_i(aword), .adc_word_valid_i(avld), .power_good_n_o(pgn),
    .clamp_pulse_o(clamp), .clamp_switch_o(csw), .video_sample_o(vsam), .ref_sample_o(rsmp),
    .ref_from_reset_o(rfr), .ref_level_code_o(rcode), .ref_dac_range_o(rrng), .ref_dac_enable_o(rdac),
    .offset_code_o(offs), .gain_code_o(gain), .nibble_o(nib), .nibble_valid_o(nvld));
  asc_strobe_model fm (.ref_clk_i(clk), .fire_i(fire), .word_i(fword), .sample_strobe_o(stb),
    .adc_word_o(aword), .adc_word_valid_o(avld));
  // ==========================================
  // helpers
  task automatic print_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer; address held until hready, data until hready
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(a, 1'b1, d, rd);
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    ahb(a, 1'b0, 32'h0000_0000, rd);
    chk(rd, e);
    chk(hresp, 1'b0);
  endtask
  task automatic px(input logic [15:0] w);
    @(posedge clk);
    fire <= 1'b1; fword <= w;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // clamp placement against the video sample for one timing code
  task automatic clamp_run(input logic [1:0] t, input logic dsel);
    int n;
    int w;
    wr(asc_pkg::ASC_OFF_CTRL, {25'h000_0000, dsel, t, 4'h8});
    px(16'h1234);
    for (n = 0; n < 10 && vsam !== 1'b1; n++) @(negedge clk);
    chk(vsam, 1'b1);
    chk(rsmp, !dsel);
    chk(rfr, dsel);
    for (n = 0; n < 10 && clamp !== 1'b1; n++) @(negedge clk);
    chk(n, 2 + t);
    chk(rsmp, dsel);
    for (w = 0; w < 10 && clamp === 1'b1; w++) begin
      chk(csw, 1'b1);
      @(negedge clk);
    end
    chk(w, CW);
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      print_verdict();
    end
  end
  // ==========================================
  // test sequence
  initial begin
    int i, k, w;
    logic [15:0] d;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wr(asc_pkg::ASC_OFF_SWRST, 32'h0000_0000);
    rdchk(asc_pkg::ASC_OFF_CTRL, asc_pkg::ASC_CTRL_RST);
    rdchk(asc_pkg::ASC_OFF_REF, asc_pkg::ASC_REF_RST);
    rdchk(asc_pkg::ASC_OFF_STATUS, 32'h0000_0001);
    rdchk(8'h40, 32'h0000_0000);
    for (i = 0; i < 3; i++) begin
      rdchk(asc_pkg::ASC_OFF_RED + 8'(4 * i), asc_pkg::ASC_SET_RST);
      wr(asc_pkg::ASC_OFF_RED + 8'(4 * i), 32'h0000_1122 + 32'(i * 32'h0000_2222));
    end
    wr(asc_pkg::ASC_OFF_REF, 32'h0000_002A);
    chk({rcode, rrng, rdac}, {4'hA, 1'b0, 1'b0});
    wr(asc_pkg::ASC_OFF_REF, 32'h0000_0015);
    chk({rcode, rrng, rdac}, {4'h5, 1'b1, 1'b1});
    // host steps the select once per colour line
    for (i = 0; i < 3; i++) begin
      wr(asc_pkg::ASC_OFF_CTRL, 32'h0000_0040 | 32'(i));
      chk({gain, offs}, 16'h1122 + 16'(i * 16'h2222));
    end
    wr(asc_pkg::ASC_OFF_CTRL, 32'h0000_0043);
    chk({gain, offs}, 16'h5566);
    wr(asc_pkg::ASC_OFF_CTRL, 32'h0000_0045);
    chk({gain, offs}, 16'h1122);
    // each supply on its own drops power good; supplies change on a rising edge
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      av <= (i != 0);
      dv <= (i == 0);
      @(negedge clk);
      chk(pgn, 1'b0);
      wr(asc_pkg::ASC_OFF_CTRL, 32'h0000_000F);
      @(posedge clk);
      av <= 1'b1;
      dv <= 1'b1;
      @(negedge clk);
      chk(pgn, 1'b1);
      rdchk(asc_pkg::ASC_OFF_CTRL, asc_pkg::ASC_CTRL_RST);
    end
    rdchk(asc_pkg::ASC_OFF_REF, asc_pkg::ASC_REF_RST);
    for (i = 0; i < 4; i++) clamp_run(2'(i), 1'b1);
    clamp_run(2'h1, 1'b0);
    // enable cleared: next strobe captures 0, no clamp; nibbles msb first
    wr(asc_pkg::ASC_OFF_CTRL, 32'h0000_0040);
    px(16'hA5C3);
    k = 0;
    w = 0;
    d = 16'h0000;
    repeat (14) begin
      @(negedge clk);
      if (clamp !== 1'b0) w++;
      if (nvld === 1'b1) begin
        d = {d[11:0], nib};
        k++;
      end
    end
    chk(w, 0);
    chk(k, 4);
    chk(d, 16'hA5C3);
    print_verdict();
  end
endmodule
`default_nettype wire
